// >>> include/energy_pkg.sv
// Shared constants and carrier types for the reactive and apparent power block.
package energy_pkg;

    // ***********************************************************
    // Register offsets (byte addresses, one 32-bit word each)
    // ***********************************************************
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  OFF_STATUS      = 8'h00;
    localparam logic [7:0]  OFF_MASK        = 8'h04;
    localparam logic [7:0]  OFF_ACC_MODE    = 8'h08;
    localparam logic [7:0]  OFF_LCYC_MODE   = 8'h0c;
    localparam logic [7:0]  OFF_HALFCYC     = 8'h10;
    localparam logic [7:0]  OFF_COMP_MODE   = 8'h14;
    localparam logic [7:0]  OFF_THR_LO      = 8'h18;
    localparam logic [7:0]  OFF_THR_HI      = 8'h1c;
    localparam logic [7:0]  OFF_NOM_VOLT    = 8'h20;
    localparam logic [7:0]  OFF_GAIN_BASE   = 8'h24;
    localparam logic [7:0]  OFF_HOURS_BASE  = 8'h30;
    localparam logic [7:0]  OFF_VA_BASE     = 8'h48;
    localparam logic [7:0]  OFF_STEP        = 8'h04;

    // ***********************************************************
    // Field positions
    // ***********************************************************
    localparam int          STAT_TOTAL_HF   = 2;
    localparam int          STAT_FUND_HF    = 3;
    localparam int          ACC_SIGN_LO     = 2;
    localparam int          ACC_COMB_LO     = 4;
    localparam int          LCY_LINE_VAR    = 1;
    localparam int          LCY_ZX_LO       = 3;
    localparam int          LCY_RD_RESET    = 6;
    localparam int          COMP_NOM_LO     = 11;
    localparam int          HALF_BIT        = 30;

    // ***********************************************************
    // Reset values and arithmetic constants
    // ***********************************************************
    localparam logic [15:0] HALFCYC_RST     = 16'hffff;
    localparam logic [25:0] FULL_POWER      = 26'h1ff_6a6b;
    localparam logic [27:0] GAIN_UNITY      = 28'h080_0000;
    localparam int          VA_SHIFT        = 4;

    // ***********************************************************
    // Timing
    // ***********************************************************
    localparam int          SAMPLE_PERIOD_NS = 125_000;
    localparam int          CLK_PERIOD_NS    = 8;
    localparam int          SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [ADDR_W-1:0]      addr;
        logic [DATA_W-1:0]      wdata;
    } reg_req_t;

    typedef struct packed {
        logic [2:0][23:0]       volt;
        logic [2:0][23:0]       curr_shift;
        logic [2:0][23:0]       fcurr_shift;
        logic [2:0][23:0]       vrms;
        logic [2:0][23:0]       irms;
        logic [2:0]             zero_cross;
    } meter_in_t;

endpackage : energy_pkg

// >>> design/reactive_apparent_energy_accum.sv
// Var-hour accumulators, half-full flags and apparent power per phase.
//
// Local design decisions: the register offsets and the address-and-strobe port.
module reactive_apparent_energy_accum
#(
    parameter int SAMPLE_CYCLES = energy_pkg::SAMPLE_CYCLES
)
(
    input  wire logic                       sys_clk,
    input  wire logic                       arst_n,
    input  wire energy_pkg::reg_req_t       bus_req,
    output logic [energy_pkg::DATA_W-1:0]   rd_data,
    input  wire energy_pkg::meter_in_t      meter_in,
    output logic                            interrupt_zero_pin_n,
    output logic [1:0]                      reactive_sign_mode
);
    import energy_pkg::*;

    // ***********************************************************
    // Helper functions
    // ***********************************************************
    function automatic logic signed [25:0] sx26(input logic [23:0] x);
        return {{2{x[23]}}, x};
    endfunction : sx26

    function automatic logic signed [26:0] react_power(
        input logic signed [25:0] v,
        input logic signed [23:0] i);
        logic signed [49:0] prod;
        prod = v * i;
        return prod[49:23];
    endfunction : react_power

    function automatic logic signed [27:0] sx28(input logic [23:0] x);
        return {{4{x[23]}}, x};
    endfunction : sx28

    // ***********************************************************
    // Sample tick
    // ***********************************************************
    logic [15:0]                tick_cnt_r;
    logic                       tick_r;
    wire logic                  tick_wrap = (tick_cnt_r ==
                                             16'(SAMPLE_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end
        else
        begin
            tick_cnt_r <= tick_wrap ? 16'h0000 : tick_cnt_r + 16'h0001;
            tick_r     <= tick_wrap;
        end
    end

    // ***********************************************************
    // Configuration registers
    // ***********************************************************
    logic [1:0]                 mask_r;
    logic [3:0]                 acc_mode_r;
    logic [6:0]                 lcyc_r;
    logic [15:0]                halfcyc_r;
    logic [2:0]                 nom_en_r;
    logic [23:0]                thr_lo_r;
    logic [23:0]                thr_hi_r;
    logic [23:0]                nom_volt_r;
    logic [2:0][23:0]           gain_r;

    wire logic                  wr = bus_req.wr;
    wire logic [7:0]            wa = bus_req.addr;
    wire logic [31:0]           wd = bus_req.wdata;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mask_r    <= 2'h0;
            acc_mode_r <= 4'h0;
            lcyc_r     <= 7'h00;
            halfcyc_r  <= HALFCYC_RST;
            nom_en_r   <= 3'h0;
            thr_lo_r   <= 24'h00_0000;
            thr_hi_r   <= 24'h00_0000;
            nom_volt_r <= 24'h00_0000;
            gain_r    <= '0;
        end
        else if (wr)
        begin
            if (wa == OFF_MASK)
                mask_r <= wd[STAT_FUND_HF:STAT_TOTAL_HF];
            if (wa == OFF_ACC_MODE)
                acc_mode_r <= wd[ACC_COMB_LO+1:ACC_SIGN_LO];
            if (wa == OFF_LCYC_MODE)
                lcyc_r <= wd[6:0];
            if (wa == OFF_HALFCYC)
                halfcyc_r <= wd[15:0];
            if (wa == OFF_COMP_MODE)
                nom_en_r <= wd[COMP_NOM_LO+2:COMP_NOM_LO];
            if (wa == OFF_THR_LO)
                thr_lo_r <= wd[23:0];
            if (wa == OFF_THR_HI)
                thr_hi_r <= wd[23:0];
            if (wa == OFF_NOM_VOLT)
                nom_volt_r <= wd[23:0];
            for (int p = 0; p < 3; p++)
                if (wa == OFF_GAIN_BASE + 8'(p * 4))
                    gain_r[p] <= wd[23:0];
        end
    end

    wire logic [1:0]            comb_sel  = acc_mode_r[3:2];
    wire logic                  line_var  = lcyc_r[LCY_LINE_VAR];
    wire logic [2:0]            zx_sel    = lcyc_r[LCY_ZX_LO+2:LCY_ZX_LO];
    // Read-reset is withheld in line-cycle mode, where it is not offered.
    wire logic                  rd_reset  = lcyc_r[LCY_RD_RESET] && !line_var;
    wire logic signed [47:0]    thr       = {thr_hi_r, thr_lo_r};

    // ***********************************************************
    // Phase voltage selection and instantaneous reactive power
    // ***********************************************************
    wire logic signed [25:0]    v_a = sx26(meter_in.volt[0]);
    wire logic signed [25:0]    v_c = sx26(meter_in.volt[2]);
    logic signed [25:0]         v_b;

    always_comb
    begin
        unique case (comb_sel)
            2'b10:   v_b = -v_a - v_c;
            2'b11:   v_b = -v_a;
            default: v_b = sx26(meter_in.volt[1]);
        endcase
    end

    wire logic signed [25:0]    v_sel [3] = '{v_a, v_b, v_c};
    wire logic                  b_off     = (comb_sel == 2'b01);

    // ***********************************************************
    // Line-cycle half-cycle counter
    // ***********************************************************
    logic [15:0]                half_cnt_r;
    wire logic                  zx_hit = |(meter_in.zero_cross & zx_sel);
    wire logic                  xfer   = line_var && zx_hit &&
                                         (half_cnt_r + 16'h0001 >= halfcyc_r);

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            half_cnt_r <= 16'h0000;
        else if (!line_var || xfer)
            half_cnt_r <= 16'h0000;
        else if (zx_hit)
            half_cnt_r <= half_cnt_r + 16'h0001;
    end

    // ***********************************************************
    // Two-stage var-hour accumulation, totals 0..2, fundamentals 3..5
    // ***********************************************************
    logic [5:0][31:0]           hours_r;
    logic [5:0]                 hf_evt;

    for (genvar j = 0; j < 6; j++)
    begin : g_acc
        localparam int          PH = j % 3;
        localparam logic [7:0]  OFF_H = OFF_HOURS_BASE + 8'(j * 4);

        logic signed [47:0]     acc_r;
        logic signed [47:0]     acc_sum;
        logic signed [47:0]     acc_nxt;
        logic signed [31:0]     step;
        logic [31:0]            int_r;
        logic [31:0]            int_sum;
        logic [31:0]            int_nxt;
        logic [31:0]            hours_nxt;

        wire logic [23:0]       cur = (j < 3) ? meter_in.curr_shift[PH]
                                              : meter_in.fcurr_shift[PH];
        wire logic signed [26:0] pw = (PH == 1 && b_off) ? 27'sd0
                                    : react_power(v_sel[PH], cur);
        wire logic              rd_hit = bus_req.rd && (bus_req.addr == OFF_H);

        always_comb
        begin
            acc_sum = acc_r + 48'(pw);
            acc_nxt = acc_r;
            step    = 32'sd0;
            if (tick_r)
            begin
                acc_nxt = acc_sum;
                if (acc_sum >= thr)
                begin
                    acc_nxt = acc_sum - thr;
                    step    = 32'sd1;
                end
                else if (acc_sum <= -thr)
                begin
                    acc_nxt = acc_sum + thr;
                    step    = -32'sd1;
                end
            end
            int_sum   = int_r + step;
            int_nxt   = int_sum;
            hours_nxt = hours_r[j];
            if (line_var)
            begin
                if (xfer)
                begin
                    hours_nxt = int_sum;
                    int_nxt   = 32'h0000_0000;
                end
            end
            else
            begin
                hours_nxt = int_sum;
                if (rd_hit && rd_reset)
                begin
                    hours_nxt = step;
                    int_nxt   = step;
                end
            end
        end

        // Clearing by read must not count as a half-full crossing.
        assign hf_evt[j] = (hours_nxt[HALF_BIT] != hours_r[j][HALF_BIT]) &&
                           !(rd_hit && rd_reset && !line_var);

        always_ff @(posedge sys_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                acc_r      <= 48'sd0;
                int_r      <= 32'h0000_0000;
                hours_r[j] <= 32'h0000_0000;
            end
            else
            begin
                acc_r      <= acc_nxt;
                int_r      <= int_nxt;
                hours_r[j] <= hours_nxt;
            end
        end
    end

    // ***********************************************************
    // Half-full status flags and interrupt pin
    // ***********************************************************
    logic [1:0]                 status_r;
    logic [1:0]                 status_nxt;
    wire logic                  st_wr  = wr && (wa == OFF_STATUS);
    wire logic [1:0]            st_clr = st_wr ? wd[STAT_FUND_HF:STAT_TOTAL_HF]
                                               : 2'b00;
    wire logic [1:0]            st_set = {|hf_evt[5:3],
                                          |hf_evt[2:0]};

    // A new crossing in the clearing cycle wins over the clear.
    assign status_nxt = (status_r & ~st_clr) | st_set;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_r             <= 2'b00;
            interrupt_zero_pin_n <= 1'b1;
        end
        else
        begin
            status_r             <= status_nxt;
            interrupt_zero_pin_n <= ~|(status_nxt & mask_r);
        end
    end

    // ***********************************************************
    // Apparent power per phase
    // ***********************************************************
    logic [2:0][23:0]           va_r;

    for (genvar p = 0; p < 3; p++)
    begin : g_va
        // The nominal register is signed; a negative value is read as zero
        // voltage, since apparent power cannot take a negative voltage.
        wire logic [23:0]        vn  = nom_volt_r[23] ? 24'h00_0000
                                                      : nom_volt_r;
        wire logic [23:0]        vv  = nom_en_r[p] ? vn
                                                    : meter_in.vrms[p];
        wire logic [47:0]        vi  = vv * meter_in.irms[p];
        wire logic [50:0]        sc  = vi[47:23] * FULL_POWER;
        wire logic [23:0]        raw = sc[50:27];
        wire logic signed [27:0] fac = GAIN_UNITY + sx28(gain_r[p]);
        wire logic signed [52:0] gp  = $signed({1'b0, raw}) * fac;

        // Offsets are taken out upstream in the rms values only.
        always_ff @(posedge sys_clk or negedge arst_n)
        begin
            if (!arst_n)
                va_r[p] <= 24'h00_0000;
            else if (tick_r)
                va_r[p] <= gp[46:23];
        end
    end

    // ***********************************************************
    // Read path
    // ***********************************************************
    logic [31:0]                rd_mux;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (bus_req.addr)
            OFF_STATUS:   rd_mux[STAT_FUND_HF:STAT_TOTAL_HF] = status_r;
            OFF_MASK:     rd_mux[STAT_FUND_HF:STAT_TOTAL_HF] = mask_r;
            OFF_ACC_MODE:  rd_mux[ACC_COMB_LO+1:ACC_SIGN_LO] = acc_mode_r;
            OFF_LCYC_MODE: rd_mux[6:0] = lcyc_r;
            OFF_HALFCYC:   rd_mux[15:0] = halfcyc_r;
            OFF_COMP_MODE: rd_mux[COMP_NOM_LO+2:COMP_NOM_LO] = nom_en_r;
            OFF_THR_LO:    rd_mux[23:0] = thr_lo_r;
            OFF_THR_HI:    rd_mux[23:0] = thr_hi_r;
            OFF_NOM_VOLT:  rd_mux[23:0] = nom_volt_r;
            default:
            begin
                for (int p = 0; p < 3; p++)
                begin
                    if (bus_req.addr == OFF_GAIN_BASE + 8'(p * 4))
                        rd_mux = {4'h0, sx28(gain_r[p])};
                    if (bus_req.addr == OFF_VA_BASE + 8'(p * 4))
                        rd_mux = {8'h00, va_r[p]};
                end
                for (int j = 0; j < 6; j++)
                    if (bus_req.addr == OFF_HOURS_BASE + 8'(j * 4))
                        rd_mux = hours_r[j];
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_data            <= 32'h0000_0000;
            reactive_sign_mode <= 2'b00;
        end
        else
        begin
            rd_data            <= bus_req.rd ? rd_mux : 32'h0000_0000;
            reactive_sign_mode <= acc_mode_r[1:0];
        end
    end

endmodule : reactive_apparent_energy_accum

// >>> tb/reactive_apparent_energy_accum_chk.sv
// Port-level assertions for the reactive and apparent energy block.
module reactive_apparent_energy_accum_chk
(
    input wire logic                          sys_clk,
    input wire logic                          arst_n,
    input wire energy_pkg::reg_req_t          bus_req,
    input wire logic [energy_pkg::DATA_W-1:0] rd_data,
    input wire energy_pkg::meter_in_t         meter_in,
    input wire logic                          interrupt_zero_pin_n,
    input wire logic [1:0]                    reactive_sign_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import energy_pkg::*;

    // ***************************************
    // Decoded requests and assertions
    // ***************************************
    wire [7:0] a       = bus_req.addr;
    wire       acc_wr  = bus_req.wr && a == OFF_ACC_MODE;
    wire       ctl_wr  = bus_req.wr && (a == OFF_STATUS || a == OFF_MASK);
    wire       stat_rd = bus_req.rd && (a == OFF_STATUS || a == OFF_MASK);
    wire       gain_rd = bus_req.rd && a >= OFF_GAIN_BASE && a <= 8'h2c;
    wire       va_rd   = bus_req.rd && a >= OFF_VA_BASE && a <= 8'h50;
    wire       bad_rd  = bus_req.rd && (a > 8'h50 || a[1:0] != 2'b00);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    idle_read_zero_a: assert property (!bus_req.rd |=> rd_data == '0)
        else $error("read data not zero outside a read answer");
    unmapped_zero_a: assert property (bad_rd |=> rd_data == '0)
        else $error("unmapped read returned data");
    flag_bits_a: assert property (stat_rd |=> (rd_data & ~32'h0000_000c) == '0)
        else $error("status or mask read shows bits beyond 3:2");
    gain_extend_a: assert property (gain_rd |=> rd_data[31:28] == 4'h0
        && rd_data[27:24] == {4{rd_data[23]}})
        else $error("gain read not sign extended to 28 bits");
    sample_width_a: assert property (va_rd |=> rd_data[31:24] == 8'h00)
        else $error("apparent sample wider than 24 bits");
    sign_copy_a: assert property (acc_wr |-> ##2
        reactive_sign_mode == $past(bus_req.wdata[3:2], 2))
        else $error("sign mode output does not follow its field");
    sign_hold_a: assert property (!acc_wr ##1 !acc_wr |=>
        $stable(reactive_sign_mode))
        else $error("sign mode output changed without a write");
    irq_release_a: assert property ($rose(interrupt_zero_pin_n) |->
        $past(ctl_wr) || $past(ctl_wr, 2))
        else $error("interrupt released without a status or mask write");

    cover property (bus_req.rd && a == OFF_HOURS_BASE);
    cover property ($fell(interrupt_zero_pin_n));
    cover property (acc_wr);
endmodule : reactive_apparent_energy_accum_chk

// >>> tb/test_reactive_apparent_energy_accum.sv
// Self-checking bench for the reactive and apparent energy block.
module test_reactive_apparent_energy_accum;
    timeunit 1ns;
    timeprecision 1ps;
    import energy_pkg::*;

    // ***************************************
    // Signals, tasks and expectations
    // ***************************************
    localparam int     S = 10;
    logic              sys_clk  = 1'b0;
    logic              arst_n   = 1'b0;
    reg_req_t          bus_req  = '0;
    meter_in_t         meter_in = '0;
    logic [DATA_W-1:0] rd_data;
    logic              interrupt_zero_pin_n;
    logic [1:0]        reactive_sign_mode;
    int                error_cnt = 0;
    int                n_checks  = 0;
    int                cyc       = 0;

    reactive_apparent_energy_accum #(.SAMPLE_CYCLES(S))
        i_reactive_apparent_energy_accum (.sys_clk(sys_clk), .arst_n(arst_n),
        .bus_req(bus_req), .rd_data(rd_data), .meter_in(meter_in),
        .interrupt_zero_pin_n(interrupt_zero_pin_n),
        .reactive_sign_mode(reactive_sign_mode));

    always #4 sys_clk = ~sys_clk;

    // The cycle count doubles as sample phase; ticks fall near multiples of S.
    always @(posedge sys_clk)
    begin
        cyc <= arst_n ? cyc + 1 : 0;
        if (cyc == 20000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (error_cnt == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus_req <= '0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge sys_clk);
        bus_req <= '0;
        #1 v = rd_data;
        @(posedge sys_clk);
    endtask : rd

    // Reads are placed mid-way between sample ticks so no pulse races them.
    task automatic align();
        do @(negedge sys_clk); while (cyc % S != S / 2);
        @(posedge sys_clk);
    endtask : align

    task automatic span(input int k);
        repeat ((k - 1) * S) @(posedge sys_clk);
        align();
    endtask : span

    task automatic zx(input int p);
        meter_in.zero_cross[p] <= 1'b1;
        @(posedge sys_clk);
        meter_in.zero_cross[p] <= 1'b0;
        @(posedge sys_clk);
    endtask : zx

    function automatic logic [31:0] va_exp(input longint v, input longint i,
                                           input longint g);
        longint x;
        x = (((v * i) >>> 23) * longint'(FULL_POWER)) >>> 27;
        x = (x * ((longint'(1) << 23) + g)) >>> 23;
        return {8'h00, x[23:0]};
    endfunction : va_exp

    initial
    begin
        logic [31:0] v, e, r0, r1;
        logic [23:0] vr[3], ir[3], g[3];
        logic [2:0]  en;
        int          dl[4] = '{-1, 0, 1, -1};
        logic [23:0] gt[3] = '{24'h00_0000, 24'h40_0000, 24'hc0_0000};
        void'($urandom(29406));
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        check(interrupt_zero_pin_n, 1'b1);
        rd(OFF_HALFCYC, v);
        check(v, 32'h0000_ffff);
        rd(8'h80, v);
        check(v, 32'h0000_0000);
        for (int k = 0; k < 3; k++)
        begin
            e = $urandom();
            wr(OFF_ACC_MODE, e);
            rd(OFF_ACC_MODE, v);
            check(v, e & 32'h0000_003c);
            check(reactive_sign_mode, e[3:2]);
        end
        wr(OFF_THR_LO, 32'h0020_0000);
        wr(OFF_THR_HI, 32'h0000_0000);
        wr(OFF_MASK, 32'h0000_000c);
        meter_in.volt[0] <= 24'h40_0000;
        meter_in.fcurr_shift[0] <= 24'hc0_0000;
        repeat (2 * S) @(posedge sys_clk);
        rd(OFF_STATUS, v);
        check(v, 32'h0000_0008);
        check(interrupt_zero_pin_n, 1'b0);
        repeat (2 * S) @(posedge sys_clk);
        rd(OFF_STATUS, v);
        check(v, 32'h0000_0008);
        meter_in.fcurr_shift[0] <= 24'h00_0000;
        wr(OFF_STATUS, 32'h0000_0008);
        rd(OFF_STATUS, v);
        check(v, 32'h0000_0000);
        check(interrupt_zero_pin_n, 1'b1);
        wr(OFF_MASK, 32'h0000_0008);
        meter_in.curr_shift[0] <= 24'hc0_0000;
        repeat (2 * S) @(posedge sys_clk);
        rd(OFF_STATUS, v);
        check(v, 32'h0000_0004);
        check(interrupt_zero_pin_n, 1'b1);
        meter_in.curr_shift[0] <= 24'h40_0000;
        align();
        rd(OFF_HOURS_BASE, r0);
        span(3);
        rd(OFF_HOURS_BASE, r1);
        check(r1, r0 + 32'd3);
        meter_in.volt[1] <= 24'hc0_0000;
        meter_in.curr_shift[1] <= 24'h40_0000;
        meter_in.volt[2] <= 24'h80_0000;
        for (int c = 0; c < 4; c++)
        begin
            wr(OFF_ACC_MODE, 32'(c) << 4);
            align();
            rd(OFF_HOURS_BASE + OFF_STEP, r0);
            span(3);
            rd(OFF_HOURS_BASE + OFF_STEP, r1);
            check(r1, r0 + 32'(3 * dl[c]));
        end
        wr(OFF_LCYC_MODE, 32'h0000_0040);
        align();
        rd(OFF_HOURS_BASE, r0);
        span(2);
        rd(OFF_HOURS_BASE, r1);
        check(r1, 32'd2);
        wr(OFF_HALFCYC, 32'h0000_0002);
        wr(OFF_LCYC_MODE, 32'h0000_000a);
        align();
        zx(0);
        zx(0);
        align();
        rd(OFF_HOURS_BASE, r0);
        zx(1);
        zx(1);
        span(2);
        rd(OFF_HOURS_BASE, r1);
        check(r1, r0);
        align();
        zx(0);
        zx(0);
        rd(OFF_HOURS_BASE, r1);
        check(r1, 32'd4);
        for (int k = 0; k < 3; k++)
        begin
            en = (k == 0) ? 3'b000 : 3'($urandom());
            e = $urandom_range(32'h007f_ffff);
            wr(OFF_NOM_VOLT, e);
            wr(OFF_COMP_MODE, {18'h0_0000, en, 11'h000});
            for (int p = 0; p < 3; p++)
            begin
                vr[p] = (k == 0) ? 24'h80_0000 : 24'($urandom_range(24'h80_0000));
                ir[p] = (k == 0) ? 24'h80_0000 : 24'($urandom_range(24'h80_0000));
                g[p] = (k == 0) ? gt[p] : 24'($urandom());
                meter_in.vrms[p] <= vr[p];
                meter_in.irms[p] <= ir[p];
                wr(OFF_GAIN_BASE + OFF_STEP * 8'(p), {8'h00, g[p]});
                rd(OFF_GAIN_BASE + OFF_STEP * 8'(p), v);
                check(v, {4'h0, {4{g[p][23]}}, g[p]});
            end
            repeat (S) @(posedge sys_clk);
            align();
            for (int p = 0; p < 3; p++)
            begin
                rd(OFF_VA_BASE + OFF_STEP * 8'(p), v);
                check(v, va_exp(en[p] ? e : vr[p], ir[p], $signed(g[p])));
            end
        end
        complete_run();
    end
endmodule : test_reactive_apparent_energy_accum

bind reactive_apparent_energy_accum reactive_apparent_energy_accum_chk
    i_reactive_apparent_energy_accum_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .bus_req(bus_req), .rd_data(rd_data), .meter_in(meter_in),
    .interrupt_zero_pin_n(interrupt_zero_pin_n),
    .reactive_sign_mode(reactive_sign_mode));
